// ### logic/hpc_pkg.sv
// host power and reset control: shared constants and types
// assumes a 20 MHz module clock and an APB register port
`default_nettype none
package hpc_pkg;
    // clock and timing base
    localparam int CLK_NS       = 50;         // mclk period
    localparam int TICK_NS      = 1000000;    // one millisecond time base
    localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
    localparam int ON_HOLD_MS   = 250;        // confirm hold before power on
    localparam int OFF_HOLD_MS  = 4000;       // cancel hold before hard off
    localparam int RST_HOLD_MS  = 4000;       // confirm hold before reset
    localparam int RST_PULSE_MS = 1000;       // reset drive width
    localparam int EXT_MAX_MS   = 5000;       // hard off extension limit
    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] PULSE_OFS  = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    // control field positions
    localparam int ON_EN_BIT   = 0;
    localparam int OFF_EN_BIT  = 1;
    localparam int RST_EN_BIT  = 2;
    localparam int BLANK_EN_BIT = 3;
    localparam int PWR_POL_BIT = 4;
    localparam int RST_POL_BIT = 5;
    // status field positions
    localparam int ST_SENSE_BIT = 0;
    localparam int ST_OK_BIT    = 1;
    localparam int ST_CAN_BIT   = 2;
    localparam int ST_BLANK_BIT = 3;
    localparam int ST_STATE_LSB = 4;
    // reset values
    localparam logic [5:0]  CTRL_RST  = 6'h00;
    localparam logic [15:0] PULSE_RST = 16'h03e8;   // 1000 ms
    // control register fields
    typedef struct packed {
        logic rst_pol;    // 1: reset drives high
        logic pwr_pol;    // 1: power switch drives high
        logic blank_en;   // blank display while host is off
        logic rst_en;     // keypad host reset
        logic off_en;     // keypad hard power off
        logic on_en;      // keypad power on
    } hpc_ctrl_t;
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_HOLD_ON  = 4'h1,
        ST_HOLD_OFF = 4'h2,
        ST_HOLD_RST = 4'h3,
        ST_DRV_ON   = 4'h4,
        ST_DRV_OFF  = 4'h5,
        ST_DRV_EXT  = 4'h6,
        ST_DRV_RST  = 4'h7
    } hpc_state_t;
endpackage : hpc_pkg
`default_nettype wire

// ### logic/hpc_top.sv
// host power and reset control: keypad-driven host on, hard off and reset
// assumes keys and power sense arrive as raw pins; apb on mclk_i
//
// Summary of operation
// - power switch pin floats except while commanding host on or off, polarity set
// - reset pin floats except while resetting host, driven at selected polarity
// - host off, confirm held 0.25 s: drive power switch for pulse width
// - host on, cancel held 4 s: drive power switch at least pulse width
// - cancel still held after pulse extends drive, at most 5 s more
// - host on, confirm held 4 s: drive reset pin for 1 s
// - after keypad-started reset pulse, the device restarts itself
// - blanking enabled: display blanked while power sense reads low
// - blanking leaves fan power and backlight at their settings
// - watchdog expiry outside a power or reset drive drives reset pin for 1 s, with no self restart after it, unless a keypad reset starts in that cycle
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module hpc_top #(
    parameter int TICK_CYC = hpc_pkg::TICK_CYC_DEF   // cycles per millisecond
) (
    input  wire logic        mclk_i,        // 20 MHz module clock
    input  wire logic        sys_rst_i,     // synchronous reset, active high
    input  wire logic        psel_i,        // apb select
    input  wire logic        penable_i,     // apb access phase
    input  wire logic        pwrite_i,      // apb write
    input  wire logic [7:0]  paddr_i,       // apb byte address
    input  wire logic [31:0] pwdata_i,      // apb write data
    output logic      [31:0] prdata_o,      // apb read data
    output logic             pready_o,      // apb ready
    output logic             pslverr_o,     // apb error, unmapped address
    input  wire logic        sense_i,       // host switched +5v pin
    input  wire logic        key_ok_i,      // confirm key pin, high pressed
    input  wire logic        key_cancel_i,  // cancel key pin, high pressed
    input  wire logic        wdog_expire_i, // watchdog expiry pulse
    output logic             pwr_sw_o,      // power switch drive level
    output logic             pwr_sw_oe_o,   // power switch drive enable
    output logic             rst_sw_o,      // host reset drive level
    output logic             rst_sw_oe_o,   // host reset drive enable
    output logic             blank_o,       // display blank request
    output logic             restart_o      // self restart pulse
);
    localparam int TW = $clog2(TICK_CYC + 1);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] sy3;
    logic [2:0] pin_s;
    logic [2:0] next_pin_s;
    logic       sense_s;
    logic       ok_s;
    logic       can_s;

    assign pin_raw = {key_cancel_i, key_ok_i, sense_i};

    // three stages; level accepted once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_comb begin
                next_pin_s[g] = (sy2[g] == sy3[g]) ? sy3[g] : pin_s[g];
            end
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    sy1[g]   <= 1'b0;
                    sy2[g]   <= 1'b0;
                    sy3[g]   <= 1'b0;
                    pin_s[g] <= 1'b0;
                end else begin
                    sy1[g]   <= pin_raw[g];
                    sy2[g]   <= sy1[g];
                    sy3[g]   <= sy2[g];
                    pin_s[g] <= next_pin_s[g];
                end
            end
        end
    endgenerate

    assign sense_s = pin_s[0];
    assign ok_s    = pin_s[1];
    assign can_s   = pin_s[2];

    // ------------------------------------------------------------
    // apb register file
    // ------------------------------------------------------------
    hpc_pkg::hpc_ctrl_t ctrl;
    hpc_pkg::hpc_ctrl_t next_ctrl;
    logic [15:0]        pulse_ms;
    logic [15:0]        next_pulse_ms;
    logic [31:0]        next_prdata;
    logic               next_pready;
    logic               next_pslverr;
    logic               acc;
    logic               hit;
    hpc_pkg::hpc_state_t state;

    assign acc = psel_i && penable_i && !pready_o;
    assign hit = (paddr_i == hpc_pkg::CTRL_OFS) || (paddr_i == hpc_pkg::PULSE_OFS)
               || (paddr_i == hpc_pkg::STATUS_OFS);

    // decode; answer one cycle into the access phase
    always_comb begin
        next_ctrl     = ctrl;
        next_pulse_ms = pulse_ms;
        next_prdata   = prdata_o;
        next_pready   = acc;
        next_pslverr  = acc && !hit;
        if (acc) begin
            next_prdata = 32'h0;
            if (pwrite_i) begin
                if (paddr_i == hpc_pkg::CTRL_OFS) begin
                    next_ctrl = pwdata_i[5:0];
                end
                if (paddr_i == hpc_pkg::PULSE_OFS) begin
                    next_pulse_ms = pwdata_i[15:0];
                end
            end else begin
                case (paddr_i)
                    hpc_pkg::CTRL_OFS:   next_prdata[5:0] = ctrl;
                    hpc_pkg::PULSE_OFS:  next_prdata[15:0] = pulse_ms;
                    hpc_pkg::STATUS_OFS: begin
                        next_prdata[hpc_pkg::ST_SENSE_BIT] = sense_s;
                        next_prdata[hpc_pkg::ST_OK_BIT]    = ok_s;
                        next_prdata[hpc_pkg::ST_CAN_BIT]   = can_s;
                        next_prdata[hpc_pkg::ST_BLANK_BIT] = blank_o;
                        next_prdata[hpc_pkg::ST_STATE_LSB +: 4] = state;
                    end
                    default: next_prdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl      <= hpc_pkg::CTRL_RST;
            pulse_ms  <= hpc_pkg::PULSE_RST;
            prdata_o  <= 32'h0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            pulse_ms  <= next_pulse_ms;
            prdata_o  <= next_prdata;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    hpc_pkg::hpc_state_t next_state;
    logic [TW-1:0]       tick_cnt;
    logic [TW-1:0]       next_tick_cnt;
    logic [15:0]         ms_cnt;
    logic [15:0]         next_ms_cnt;
    logic                tick;
    logic                wd_src;
    logic                next_wd_src;
    logic                next_pwr_sw;
    logic                next_pwr_oe;
    logic                next_rst_sw;
    logic                next_rst_oe;
    logic                next_blank;
    logic                next_restart;

    assign tick = (tick_cnt == TW'(TICK_CYC - 1));

    // reports a millisecond count reached at this tick
    function automatic logic ms_done(input logic [15:0] cnt, input int lim);
        ms_done = (cnt == 16'(lim - 1));
    endfunction

    // state, time base and pin drive; timers restart on each state change
    always_comb begin
        next_state   = state;
        next_wd_src  = wd_src;
        next_restart = 1'b0;
        case (state)
            hpc_pkg::ST_IDLE: begin
                if (ctrl.on_en && !sense_s && ok_s) begin
                    next_state = hpc_pkg::ST_HOLD_ON;
                end else if (ctrl.rst_en && sense_s && ok_s) begin
                    next_state = hpc_pkg::ST_HOLD_RST;
                end else if (ctrl.off_en && sense_s && can_s) begin
                    next_state = hpc_pkg::ST_HOLD_OFF;
                end
            end
            hpc_pkg::ST_HOLD_ON: begin
                if (!ok_s || sense_s) begin
                    next_state = hpc_pkg::ST_IDLE;
                end else if (tick && ms_done(ms_cnt, hpc_pkg::ON_HOLD_MS)) begin
                    next_state = hpc_pkg::ST_DRV_ON;
                end
            end
            hpc_pkg::ST_HOLD_OFF: begin
                if (!can_s || !sense_s) begin
                    next_state = hpc_pkg::ST_IDLE;
                end else if (tick && ms_done(ms_cnt, hpc_pkg::OFF_HOLD_MS)) begin
                    next_state = hpc_pkg::ST_DRV_OFF;
                end
            end
            hpc_pkg::ST_HOLD_RST: begin
                if (!ok_s || !sense_s) begin
                    next_state = hpc_pkg::ST_IDLE;
                end else if (tick && ms_done(ms_cnt, hpc_pkg::RST_HOLD_MS)) begin
                    next_state  = hpc_pkg::ST_DRV_RST;
                    next_wd_src = 1'b0;
                end
            end
            hpc_pkg::ST_DRV_ON: begin
                if (tick && ms_done(ms_cnt, int'(pulse_ms))) begin
                    next_state = hpc_pkg::ST_IDLE;
                end
            end
            hpc_pkg::ST_DRV_OFF: begin
                if (tick && ms_done(ms_cnt, int'(pulse_ms))) begin
                    next_state = can_s ? hpc_pkg::ST_DRV_EXT : hpc_pkg::ST_IDLE;
                end
            end
            hpc_pkg::ST_DRV_EXT: begin
                if (!can_s || (tick && ms_done(ms_cnt, hpc_pkg::EXT_MAX_MS))) begin
                    next_state = hpc_pkg::ST_IDLE;
                end
            end
            hpc_pkg::ST_DRV_RST: begin
                if (tick && ms_done(ms_cnt, hpc_pkg::RST_PULSE_MS)) begin
                    next_state   = hpc_pkg::ST_IDLE;
                    next_restart = !wd_src;
                end
            end
            default: next_state = hpc_pkg::ST_IDLE;
        endcase
        // watchdog takes the reset line unless a power or reset drive is under way or a keypad reset starts this cycle
        if (wdog_expire_i && (next_state != hpc_pkg::ST_DRV_RST)
            && (state < hpc_pkg::ST_DRV_ON)) begin
            next_state  = hpc_pkg::ST_DRV_RST;
            next_wd_src = 1'b1;
        end
        if (next_state != state) begin
            next_tick_cnt = '0;
            next_ms_cnt   = 16'h0;
        end else begin
            next_tick_cnt = tick ? '0 : tick_cnt + TW'(1);
            next_ms_cnt   = tick ? ms_cnt + 16'h1 : ms_cnt;
        end
        next_pwr_oe = (next_state == hpc_pkg::ST_DRV_ON) || (next_state == hpc_pkg::ST_DRV_OFF)
                    || (next_state == hpc_pkg::ST_DRV_EXT);
        next_pwr_sw = next_pwr_oe && ctrl.pwr_pol;
        next_rst_oe = (next_state == hpc_pkg::ST_DRV_RST);
        next_rst_sw = next_rst_oe && ctrl.rst_pol;
        // only the display is blanked; fan and backlight are untouched
        next_blank  = ctrl.blank_en && !sense_s;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state       <= hpc_pkg::ST_IDLE;
            tick_cnt    <= '0;
            ms_cnt      <= 16'h0;
            wd_src      <= 1'b0;
            pwr_sw_o    <= 1'b0;
            pwr_sw_oe_o <= 1'b0;
            rst_sw_o    <= 1'b0;
            rst_sw_oe_o <= 1'b0;
            blank_o     <= 1'b0;
            restart_o   <= 1'b0;
        end else begin
            state       <= next_state;
            tick_cnt    <= next_tick_cnt;
            ms_cnt      <= next_ms_cnt;
            wd_src      <= next_wd_src;
            pwr_sw_o    <= next_pwr_sw;
            pwr_sw_oe_o <= next_pwr_oe;
            rst_sw_o    <= next_rst_sw;
            rst_sw_oe_o <= next_rst_oe;
            blank_o     <= next_blank;
            restart_o   <= next_restart;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    // drive enables follow the drive states and nothing else
    pwr_float_a: assert property (pwr_sw_oe_o == ((state == hpc_pkg::ST_DRV_ON)
        || (state == hpc_pkg::ST_DRV_OFF) || (state == hpc_pkg::ST_DRV_EXT)))
        else $error("power switch driven outside a power command");
    rst_float_a: assert property (rst_sw_oe_o == (state == hpc_pkg::ST_DRV_RST))
        else $error("reset pin driven outside a reset");
    // levels are registered from the polarity that stood one cycle earlier
    pwr_level_a: assert property (pwr_sw_oe_o |-> pwr_sw_o == $past(ctrl.pwr_pol))
        else $error("power switch level differs from polarity");
    rst_level_a: assert property (rst_sw_oe_o |-> rst_sw_o == $past(ctrl.rst_pol)
        && !pwr_sw_oe_o)
        else $error("reset pin level or exclusivity wrong");
    // a completed hold starts its drive at the next edge
    on_start_a: assert property (state == hpc_pkg::ST_HOLD_ON && ok_s
        && !sense_s && tick && ms_cnt == 16'(hpc_pkg::ON_HOLD_MS - 1)
        && !wdog_expire_i |=> pwr_sw_oe_o)
        else $error("power on drive did not start after hold");
    off_start_a: assert property (state == hpc_pkg::ST_HOLD_OFF && can_s
        && sense_s && tick && ms_cnt == 16'(hpc_pkg::OFF_HOLD_MS - 1)
        && !wdog_expire_i |=> state == hpc_pkg::ST_DRV_OFF)
        else $error("hard off drive did not start after hold");
    // extension only while cancel stays held, and never past its limit
    ext_start_a: assert property (state == hpc_pkg::ST_DRV_OFF && can_s
        && tick && ms_cnt == pulse_ms - 16'h1 |=> state == hpc_pkg::ST_DRV_EXT)
        else $error("held cancel did not extend the drive");
    ext_end_a: assert property (state == hpc_pkg::ST_DRV_EXT && !can_s
        |=> state == hpc_pkg::ST_IDLE)
        else $error("extension outlived the cancel key");
    ext_limit_a: assert property (state == hpc_pkg::ST_DRV_EXT
        |-> ms_cnt < 16'(hpc_pkg::EXT_MAX_MS))
        else $error("hard off extension beyond limit");
    rst_width_a: assert property ($rose(rst_sw_oe_o) && !wd_src |-> ms_cnt == 16'h0)
        else $error("reset pulse timer not restarted");
    restart_a: assert property (state == hpc_pkg::ST_DRV_RST && !wd_src
        && tick && ms_cnt == 16'(hpc_pkg::RST_PULSE_MS - 1)
        |=> restart_o ##1 !restart_o)
        else $error("no restart after keypad reset");
    restart_src_a: assert property (restart_o
        |-> $past(state) == hpc_pkg::ST_DRV_RST && !$past(wd_src))
        else $error("restart without a keypad reset");
    // blank request is registered one cycle behind enable and sense
    blank_a: assert property (ctrl.blank_en && !sense_s |=> blank_o)
        else $error("display not blanked while host off");
    blank_off_a: assert property (!ctrl.blank_en || sense_s |=> !blank_o)
        else $error("display blanked while host on or disabled");
    wdog_a: assert property (wdog_expire_i && state == hpc_pkg::ST_IDLE
        |=> rst_sw_oe_o)
        else $error("watchdog expiry did not drive reset");
    cancel_a: assert property (state == hpc_pkg::ST_HOLD_ON && !ok_s
        && !wdog_expire_i |=> state == hpc_pkg::ST_IDLE ##1 !pwr_sw_oe_o)
        else $error("early release did not cancel");

    on_cov_c:     cover property (state == hpc_pkg::ST_DRV_ON);
    ext_cov_c:    cover property (state == hpc_pkg::ST_DRV_EXT);
    rst_cov_c:    cover property (restart_o);
    wd_cov_c:     cover property (rst_sw_oe_o && wd_src);
    cancel_cov_c: cover property (state == hpc_pkg::ST_HOLD_ON ##1 state == hpc_pkg::ST_IDLE);

endmodule : hpc_top
`default_nettype wire

// ### verif/hpc_host_model.sv
// host motherboard model: switch inputs with pull to idle, supply state
// assumes sequencer drive pins and the press levels chosen by the bench
`timescale 1ns/1ps
`default_nettype none
module hpc_host_model (
    input  wire logic clk_i,      // module clock
    input  wire logic rst_i,      // bench reset
    input  wire logic pwr_sw_i,   // power switch drive level
    input  wire logic pwr_oe_i,   // power switch drive enable
    input  wire logic rst_sw_i,   // reset drive level
    input  wire logic rst_oe_i,   // reset drive enable
    input  wire logic pwr_pol_i,  // level that counts as a power press
    input  wire logic rst_pol_i,  // level that counts as a reset press
    output logic      pwr_line_o, // resolved power switch wire
    output logic      rst_line_o, // resolved reset wire
    output logic      sense_o     // host switched supply
);
    logic was_press;
    // released pins are pulled to the idle level, never left at last value
    assign pwr_line_o = pwr_oe_i ? pwr_sw_i : !pwr_pol_i;
    assign rst_line_o = rst_oe_i ? rst_sw_i : !rst_pol_i;
    // a completed press toggles the supply like a front-panel button
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            was_press <= 1'b0;
            sense_o   <= 1'b0;
        end else begin
            was_press <= (pwr_line_o == pwr_pol_i);
            if (was_press && pwr_line_o != pwr_pol_i) begin
                sense_o <= !sense_o;
            end
        end
    end
endmodule : hpc_host_model
`default_nettype wire

// ### verif/host_power_reset_control_test.sv
// testbench: apb configuration, keypad holds and watchdog against timing formulas
// assumes hpc_top with a shortened millisecond tick and the host model
`timescale 1ns/1ps
`default_nettype none
module host_power_reset_control_test;
    localparam int TICK = 4;
    logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sense, key_ok, key_cancel, wdog, pwr_sw, pwr_oe, rst_sw, rst_oe;
    logic        blank, restart, pwr_line, rst_line, err, pwr_pol, rst_pol;
    int          fail_count, tests_run, pw, r;
    hpc_top #(.TICK_CYC(TICK)) i_dut (
        .mclk_i(mclk), .sys_rst_i(sys_rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sense_i(sense), .key_ok_i(key_ok),
        .key_cancel_i(key_cancel), .wdog_expire_i(wdog), .pwr_sw_o(pwr_sw),
        .pwr_sw_oe_o(pwr_oe), .rst_sw_o(rst_sw), .rst_sw_oe_o(rst_oe),
        .blank_o(blank), .restart_o(restart));
    hpc_host_model i_host (
        .clk_i(mclk), .rst_i(sys_rst), .pwr_sw_i(pwr_sw), .pwr_oe_i(pwr_oe),
        .rst_sw_i(rst_sw), .rst_oe_i(rst_oe), .pwr_pol_i(pwr_pol),
        .rst_pol_i(rst_pol), .pwr_line_o(pwr_line), .rst_line_o(rst_line),
        .sense_o(sense));
    // ----------------------------------------------------------------
    // clock, comparison and closing
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic near(input int seen, input int exp, input int tol);
        check(32'(seen >= exp - tol && seen <= exp + tol), 32'h1);
    endtask : near
    task automatic final_report;
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        #(64'd95000 * 50);
        fail_count++;
        final_report();
    end
    // ----------------------------------------------------------------
    // apb master and drive measurement
    // ----------------------------------------------------------------
    task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic set_ctrl(input logic [5:0] v);
        pwr_pol <= v[4];
        rst_pol <= v[5];
        apb(1'b1, hpc_pkg::CTRL_OFS, {26'h0, v});
    endtask : set_ctrl
    // kind 0 watchdog pulse, 1 confirm key, 2 cancel key; rel lets go at drive start
    task automatic run(input int kind, input bit rs_pin, input int hold_ms,
                       input int exp_ms, input bit rel, input bit exp_rs);
        int  lat, wid, bad;
        bit  oe, rs;
        lat = 0; wid = 0; bad = 0; oe = 0; rs = 0;
        if (kind == 0) begin
            wdog <= 1'b1;
            @(posedge mclk);
            wdog <= 1'b0;
        end else if (kind == 1) key_ok <= 1'b1;
        else key_cancel <= 1'b1;
        while (!oe && lat < TICK * hold_ms + 60) begin
            @(posedge mclk);
            lat++;
            oe = rs_pin ? rst_oe : pwr_oe;
        end
        if (rel) begin
            key_ok <= 1'b0;
            key_cancel <= 1'b0;
        end
        while (oe && wid < 40000) begin
            if ((rs_pin ? rst_line : pwr_line) !== (rs_pin ? rst_pol : pwr_pol)) bad++;
            wid++;
            @(posedge mclk);
            oe = rs_pin ? rst_oe : pwr_oe;
            rs = restart;
        end
        if (!rel) begin
            key_ok <= 1'b0;
            key_cancel <= 1'b0;
        end
        if (exp_ms == 0) check(wid, 0);
        else near(lat, TICK * hold_ms + 5, 5);
        if (exp_ms > 0) near(wid, TICK * exp_ms, 2);
        check(bad, 0);
        check(rs, exp_rs);
        repeat (10) @(posedge mclk);
    endtask : run
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(10168));
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {key_ok, key_cancel, wdog, pwr_pol, rst_pol} = 5'h0;
        fail_count = 0;
        tests_run = 0;
        pw = 5 + $urandom_range(10);
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        apb(1'b0, hpc_pkg::CTRL_OFS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, hpc_pkg::PULSE_OFS, 32'h0);
        check(rd, 32'h3e8);
        apb(1'b1, hpc_pkg::PULSE_OFS, 32'hffff_0000 | pw);
        apb(1'b0, hpc_pkg::PULSE_OFS, 32'h0);
        check(rd, pw);
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        check(err, 1'b1);
        apb(1'b0, 8'h0c, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        check(blank, 1'b0);
        set_ctrl(6'h09);
        repeat (5) @(posedge mclk);
        check(blank, 1'b1);
        r = 100 + $urandom_range(700);
        // confirm let go before the hold ends; cancel does nothing with host off
        key_ok <= 1'b1;
        repeat (r) @(posedge mclk);
        key_ok <= 1'b0;
        run(2, 0, 250, 0, 1, 0);
        set_ctrl(6'h0b);
        run(1, 0, 250, pw, 1, 0);
        check(blank, 1'b0);
        apb(1'b0, hpc_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h1);
        run(2, 0, 4000, pw, 1, 0);
        set_ctrl(6'h1b);
        run(1, 0, 250, pw, 1, 0);
        run(2, 0, 4000, pw + 5000, 0, 0);
        run(1, 0, 250, pw, 1, 0);
        set_ctrl({1'($urandom_range(1)), 5'h17});
        run(1, 1, 4000, 1000, 1, 1);
        run(0, 1, 0, 1000, 1, 0);
        final_report();
    end
endmodule : host_power_reset_control_test
`default_nettype wire
